// *** dv/sacs_host_model.sv ***
// host controller model driving the converter's serial pins
`timescale 1ns/1ps
module sacs_host_model #(
    parameter int HALF_CYC = 4
) (
    // clock
    input wire logic core_clk,
    // pins toward the converter
    output logic convert_start,
    output logic serial_data_in,
    output logic serial_clk,
    // pins from the converter
    input wire logic serial_data_out,
    input wire logic serial_data_out_oe,
    input wire logic convDone
);
    logic fourWire; // select via data line
    logic chainMode; // data line feeds the chain
    int halfCyc = HALF_CYC; // serial clock half period, raised for a slow host

    // idle pins: clock parked high, device selected
    initial begin
        convert_start = 1'b0;
        serial_data_in = 1'b1;
        serial_clk = 1'b1;
        fourWire = 1'b0;
        chainMode = 1'b0;
    end

    // wait whole cycles, landing just after the edge
    task automatic pause(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // selection by own line keeps neighbours on a shared board quiet
    task automatic select_dev();
        if (fourWire) begin
            serial_data_in = 1'b0;
        end else begin
            convert_start = 1'b0;
        end
    endtask

    // strap the option, start, and wait for the result with the clock parked
    task automatic convert(input logic chain, input logic four, input logic busy,
                           output logic timedOut);
        int n;
        fourWire = four;
        chainMode = chain;
        convert_start = 1'b0;
        serial_data_in = !chain;
        pause(4);
        convert_start = 1'b1; // strap held across the edge
        pause(4);
        if (busy) select_dev(); // still selected at the end asks for busy bit
        n = 0;
        while (convDone !== 1'b1 && n < 400) begin // no clock while converting
            pause(1);
            n++;
        end
        timedOut = (n >= 400);
    endtask

    // clock out one frame, sampling each bit just before its falling edge
    task automatic frame(input int nBits, input logic busy, input logic [7:0] pat,
                         output logic [40:0] got, output logic oeOk);
        got = '0;
        oeOk = 1'b1;
        if (chainMode) serial_data_in = pat[7];
        if (!busy) select_dev();
        pause(8);
        for (int i = 0; i < nBits; i++) begin
            if (serial_data_out_oe !== 1'b1) oeOk = 1'b0;
            // a floating output reads as the inverse of the level on serial_data_out
            got = {got[39:0], serial_data_out ^ !serial_data_out_oe};
            serial_clk = 1'b0;
            pause(halfCyc);
            serial_clk = 1'b1;
            if (chainMode) serial_data_in = pat[7 - ((i + 1) % 8)];
            pause(halfCyc);
        end
    endtask
endmodule

// *** dv/sacs_sequencer_sva.sv ***
// port-level concurrent checks for the conversion sequencer
`timescale 1ns/1ps
`include "sacs_cfg.svh"
module sacs_sequencer_sva import sacs_pkg::*; (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // capacitor array side
    input wire logic comparatorHigh,
    input wire logic [`SACS_RES_BITS-1:0] dacTrial,
    input wire logic sampleConnect,
    input wire logic inputIsolate,
    input wire logic powerDown,
    input wire logic oscEnable,
    // status and serial enable
    input wire logic convDone,
    input wire logic modeChain,
    input wire logic serial_data_out_oe
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    // cycles spent isolated, so the window length can be judged at its end
    logic [7:0] isoCnt_ff;

    // count isolated cycles, clear as soon as the inputs reconnect
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            isoCnt_ff <= 8'h00;
        end else if (inputIsolate) begin
            isoCnt_ff <= isoCnt_ff + 8'h01;
        end else begin
            isoCnt_ff <= 8'h00;
        end
    end

    a_conv_len_fixed: assert property ($fell(inputIsolate) |-> isoCnt_ff == 8'h8c)
        else $error("conversion window not 140 cycles");
    a_dac_step_hold: assert property ($rose(inputIsolate) |=> $stable(dacTrial)[*6])
        else $error("trial code moved inside a step");
    a_iso_decode: assert property (inputIsolate |-> oscEnable && !sampleConnect && !powerDown)
        else $error("conversion outputs disagree");
    a_idle_decode: assert property (!inputIsolate |-> !oscEnable && sampleConnect)
        else $error("idle outputs disagree");
    a_done_in_acq: assert property (convDone |-> powerDown && sampleConnect && !inputIsolate)
        else $error("result stored while powered");
    a_done_one_cycle: assert property (convDone |=> !convDone)
        else $error("done pulse too long");
    a_conv_float: assert property (inputIsolate |-> !serial_data_out_oe)
        else $error("serial output driven during conversion");
    a_dac_midscale: assert property ($rose(inputIsolate) |-> dacTrial == 16'h8000)
        else $error("first trial not midscale");
    a_dac_msb_decide: assert property ($rose(inputIsolate) ##7 1'b1
        |=> dacTrial[15] == $past(comparatorHigh) && dacTrial[14] && !dacTrial[13])
        else $error("msb decision wrong");
    a_mode_hold: assert property (inputIsolate && $past(inputIsolate) |-> $stable(modeChain))
        else $error("option changed mid conversion");
endmodule

// *** dv/tb_sacs_sequencer.sv ***
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps

bind sacs_sequencer sacs_sequencer_sva sacs_sequencer_sva_inst (
    .core_clk(core_clk), .arst_n(arst_n), .comparatorHigh(comparatorHigh),
    .dacTrial(dacTrial), .sampleConnect(sampleConnect), .inputIsolate(inputIsolate),
    .powerDown(powerDown), .oscEnable(oscEnable), .convDone(convDone),
    .modeChain(modeChain), .serial_data_out_oe(serial_data_out_oe));

module tb_sacs_sequencer;
    // clock, reset, bookkeeping
    logic core_clk;
    logic arst_n;
    int cycles = 0;
    int n_mismatch = 0;
    int compares = 0;
    // host pins
    logic convert_start, serial_data_in, serial_clk, serial_data_out, serial_data_out_oe;
    // analog stand-in: the input expressed as a code
    logic [15:0] target;
    logic comparatorHigh;
    logic [15:0] dacTrial;
    // status outputs
    logic sampleConnect, inputIsolate, powerDown, oscEnable, convDone, modeChain, modeBusy;
    // codes at the ends and the middle of the range
    logic [15:0] corners [4] = '{16'h0000, 16'h8000, 16'h7fff, 16'hffff};

    sacs_sequencer sacs_sequencer_inst (.core_clk(core_clk), .arst_n(arst_n),
        .convert_start(convert_start), .serial_data_in(serial_data_in),
        .serial_clk(serial_clk), .serial_data_out(serial_data_out),
        .serial_data_out_oe(serial_data_out_oe), .comparatorHigh(comparatorHigh),
        .dacTrial(dacTrial), .sampleConnect(sampleConnect), .inputIsolate(inputIsolate),
        .powerDown(powerDown), .oscEnable(oscEnable), .convDone(convDone),
        .modeChain(modeChain), .modeBusy(modeBusy));

    sacs_host_model sacs_host_model_inst (.core_clk(core_clk),
        .convert_start(convert_start), .serial_data_in(serial_data_in),
        .serial_clk(serial_clk), .serial_data_out(serial_data_out),
        .serial_data_out_oe(serial_data_out_oe), .convDone(convDone));

    // 100 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // ideal comparator, updated just after each edge like any other input
    always @(posedge core_clk) begin
        #1;
        comparatorHigh = (target >= dacTrial);
    end

    // hang guard, well above the expected run length
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    // verdict and end of run
    task automatic wrap_up();
        if (n_mismatch == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // one comparison, reported on mismatch
    task automatic check(input logic [40:0] got, input logic [40:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // bits on the wire: busy bit reads as a leading zero, chain appends the fed bits
    function automatic logic [40:0] expect_frame(input logic chain, input logic [15:0] code,
                                                 input logic [7:0] pat);
        logic [40:0] v;
        v = {25'h0, code};
        if (chain) v = {v[32:0], pat};
        return v;
    endfunction

    // one conversion and its readout in the given option
    task automatic run_one(input int mode, input logic [15:0] code);
        logic chain, four, busy, tmo, oeOk;
        logic [40:0] got;
        logic [7:0] pat;
        int nBits;
        chain = (mode >= 4);
        four = mode[1] && !chain;
        busy = mode[0];
        pat = 8'($urandom);
        nBits = 16 + int'(busy) + (chain ? 8 : 0);
        target = code;
        sacs_host_model_inst.convert(chain, four, busy, tmo);
        check({40'h0, tmo}, 41'h0, "conversion done");
        check({39'h0, modeChain, modeBusy}, {39'h0, chain, busy}, "option");
        sacs_host_model_inst.frame(nBits, busy, pat, got, oeOk);
        check(got, expect_frame(chain, code, pat), "frame");
        check({40'h0, oeOk}, 41'h1, "driven in frame");
        if (!chain) check({40'h0, serial_data_out_oe}, 41'h0, "float at end");
    endtask

    // reset, then every option with corner and random codes
    initial begin
        arst_n = 1'b0;
        target = 16'h0000;
        comparatorHigh = 1'b0;
        repeat (16) @(posedge core_clk);
        #1;
        arst_n = 1'b1;
        void'($urandom(86963));
        for (int m = 0; m < 6; m++) begin
            foreach (corners[k]) run_one(m, corners[k]);
            repeat (3) run_one(m, 16'($urandom));
        end
        // slow host clock, options drawn at random
        sacs_host_model_inst.halfCyc = 7;
        repeat (6) run_one(int'($urandom_range(5, 0)), 16'($urandom));
        wrap_up();
    end
endmodule

// *** logic/sacs_cfg.svh ***
// timing, layout and code constants for the conversion sequencer
`ifndef SACS_CFG_SVH
`define SACS_CFG_SVH

// core clock period in ns (100 MHz)
`define SACS_CLK_PERIOD_NS 10
// longest conversion time in ns
`define SACS_CONV_TIME_NS 1400
// conversion length in core cycles, a longest time so it rounds down
`define SACS_CONV_CYC (`SACS_CONV_TIME_NS / `SACS_CLK_PERIOD_NS)
// result resolution in bits
`define SACS_RES_BITS 16
// cycles spent on each successive-approximation step
`define SACS_SAR_STEP_CYC (`SACS_CONV_CYC / `SACS_RES_BITS)
// width of the conversion and step counters
`define SACS_CNT_W 8

// result fifo geometry
`define SACS_FIFO_WIDTH 16
`define SACS_FIFO_DEPTH 32

// straight binary codes: zero, midscale, full scale
`define SACS_CODE_ZERO 16'h0000
`define SACS_CODE_MID 16'h8000
`define SACS_CODE_FULL 16'hffff

// level of the busy indicator bit
`define SACS_BUSY_LEVEL 1'b0
// frame lengths in falling serial clock edges
`define SACS_FRAME_BUSY 5'h11
`define SACS_FRAME_PLAIN 5'h10

// index of each host pin inside the pin vector
`define SACS_PIN_SCLK 0
`define SACS_PIN_SDI 1
`define SACS_PIN_CONV 2

`endif

// *** logic/sacs_fifo.sv ***
// result fifo with valid/ready on both sides
`timescale 1ns/1ps
module sacs_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);

    localparam int AW = $clog2(DEPTH);

    logic [AW-1:0] wrPtr_ff; // next slot to write
    logic [AW-1:0] rdPtr_ff; // head slot
    logic [AW:0] count_ff; // words visible to the drain side
    logic wrPend_ff; // word written last cycle, not yet counted
    logic [AW:0] used; // slots taken including the pending one
    logic [AW-1:0] rdAddr; // address fed to the registered read
    logic push;
    logic pop;

    // a write is only counted one cycle later, when the registered read can see it
    assign used = count_ff + (AW + 1)'(wrPend_ff);
    assign inReady = used < (AW + 1)'(DEPTH);
    assign outValid = count_ff != '0;
    assign push = inValid & inReady;
    assign pop = outValid & outReady;
    // read ahead so that the new head is in the data register after a pop
    assign rdAddr = pop ? rdPtr_ff + 1'b1 : rdPtr_ff;

    // pointers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
        end else begin
            if (push) begin
                wrPtr_ff <= wrPtr_ff + 1'b1;
            end
            if (pop) begin
                rdPtr_ff <= rdPtr_ff + 1'b1;
            end
        end
    end

    // occupancy
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            count_ff <= '0;
            wrPend_ff <= 1'b0;
        end else begin
            wrPend_ff <= push;
            count_ff <= count_ff + (AW + 1)'(wrPend_ff) - (AW + 1)'(pop);
        end
    end

    sacs_ram #(
        .WIDTH(WIDTH),
        .DEPTH(DEPTH)
    ) uRam (
        .core_clk(core_clk),
        .wrEn(push),
        .wrAddr(wrPtr_ff),
        .wrData(inData),
        .rdAddr(rdAddr),
        .rdData(outData)
    );

endmodule

// *** logic/sacs_pkg.sv ***
// types shared by the conversion sequencer files
package sacs_pkg;

    // sequencer states, gray coded along acquire -> convert -> store
    typedef enum logic [1:0] {
        SEQ_ACQ = 2'b00,
        SEQ_CONV = 2'b01,
        SEQ_STORE = 2'b11
    } sacs_seq_t;

    // interface option latched per conversion
    typedef struct packed {
        logic chain;
        logic busy;
    } sacs_mode_t;

    // host pins, one bit each
    typedef struct packed {
        logic convStart;
        logic dataIn;
        logic sclk;
    } sacs_pins_t;

endpackage

// *** logic/sacs_ram.sv ***
// small dual-port word memory with registered read data
`timescale 1ns/1ps
module sacs_ram #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    // clock
    input wire logic core_clk,
    // write port
    input wire logic wrEn,
    input wire logic [$clog2(DEPTH)-1:0] wrAddr,
    input wire logic [WIDTH-1:0] wrData,
    // read port
    input wire logic [$clog2(DEPTH)-1:0] rdAddr,
    output logic [WIDTH-1:0] rdData
);

    logic [WIDTH-1:0] mem [DEPTH]; // storage, no reset needed

    // write port
    always_ff @(posedge core_clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    // read port, old data wins on a same-address collision
    always_ff @(posedge core_clk) begin
        rdData <= mem[rdAddr];
    end

endmodule

// *** logic/sacs_sequencer.sv ***
// conversion sequencer and serial result port of the sar converter
//
// Behaviour
// R1 - fixed conversion time from internal timebase, 1400 ns
// R2 - sample at start, isolate inputs during conversion
// R3 - reconnect, power down, result readable in acquisition
// R4 - six options: 3/4-wire select, chain, busy
// R5 - busy options send one bit before result
// R6 - chain mode shifts data through like register
// R7 - host selects each converter by its own line
// R8 - data input high at start edge selects mode
// R9 - start edge samples and floats serial output
// R10 - msb on select, shift on falling clock, float
// R11 - straight binary result, midscale is 8000
// R12 - host keeps serial clock idle during conversion
`timescale 1ns/1ps
`include "sacs_cfg.svh"
module sacs_sequencer import sacs_pkg::*; (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // host pins
    input wire logic convert_start,
    input wire logic serial_data_in,
    input wire logic serial_clk,
    output logic serial_data_out,
    output logic serial_data_out_oe,
    // capacitor array and comparator
    input wire logic comparatorHigh,
    output logic [`SACS_RES_BITS-1:0] dacTrial,
    output logic sampleConnect,
    output logic inputIsolate,
    output logic powerDown,
    output logic oscEnable,
    // status
    output logic convDone,
    output logic modeChain,
    output logic modeBusy
);

    localparam logic [`SACS_CNT_W-1:0] CONV_LAST = `SACS_CNT_W'(`SACS_CONV_CYC - 1);
    localparam logic [`SACS_CNT_W-1:0] STEP_LAST = `SACS_CNT_W'(`SACS_SAR_STEP_CYC - 1);

    // pin synchronisers and edges
    sacs_pins_t pinRaw; // pins as they arrive
    logic [2:0] rawVec; // same, as a vector
    logic [2:0] syncA_ff; // first stage, read only by the second
    logic [2:0] syncB_ff; // second stage
    logic [2:0] syncC_ff; // third stage
    logic [2:0] pinFilt_ff; // accepted level
    logic [2:0] pinPrev_ff; // accepted level one cycle back
    logic startRise; // convert_start rising
    logic sclkFall; // serial clock falling
    logic selNow; // converter selected for readout
    logic selPrev_ff; // selection one cycle back

    // sequencer
    sacs_seq_t seq_ff; // sequencer state
    logic [`SACS_CNT_W-1:0] convCnt_ff; // cycles into the conversion
    logic [`SACS_CNT_W-1:0] stepCnt_ff; // cycles into the current bit trial
    logic [`SACS_RES_BITS-1:0] sarCode_ff; // code under trial / final code
    logic [`SACS_RES_BITS-1:0] trialBit_ff; // one-hot bit under trial
    sacs_mode_t mode_ff; // interface option of this conversion
    logic convDone_ff; // pulse when the result is stored

    // result fifo
    logic fifoInReady;
    logic fifoOutValid;
    logic [`SACS_FIFO_WIDTH-1:0] fifoOutData;
    logic pushDone; // result accepted this cycle
    logic popNow; // head loaded into the shifter this cycle

    // serial shifter
    logic [`SACS_RES_BITS:0] shReg_ff; // bit 16 drives the output
    logic [4:0] bitsLeft_ff; // falling edges left in the frame
    logic sdoOe_ff; // output driven
    logic loadPend_ff; // waiting for the head word
    logic pendBusy_ff; // pending frame carries the busy bit

    // three flip-flops per pin; a change counts once stages two and three agree
    assign pinRaw = '{convStart: convert_start, dataIn: serial_data_in, sclk: serial_clk};
    assign rawVec = pinRaw;
    for (genvar g = 0; g < 3; g++) begin : gSync
        always_ff @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
                syncA_ff[g] <= 1'b0;
                syncB_ff[g] <= 1'b0;
                syncC_ff[g] <= 1'b0;
                pinFilt_ff[g] <= 1'b0;
                pinPrev_ff[g] <= 1'b0;
            end else begin
                syncA_ff[g] <= rawVec[g];
                syncB_ff[g] <= syncA_ff[g];
                syncC_ff[g] <= syncB_ff[g];
                // glitch of one sample never reaches the edge detectors
                if (syncB_ff[g] == syncC_ff[g]) begin
                    pinFilt_ff[g] <= syncB_ff[g];
                end
                pinPrev_ff[g] <= pinFilt_ff[g];
            end
        end
    end

    // edges of the accepted levels
    assign startRise = pinFilt_ff[`SACS_PIN_CONV] & ~pinPrev_ff[`SACS_PIN_CONV];
    assign sclkFall = ~pinFilt_ff[`SACS_PIN_SCLK] & pinPrev_ff[`SACS_PIN_SCLK];

    // chain mode selects with convert_start low; select mode with either line low,
    // since 3-wire ties the data input high and 4-wire keeps convert_start high
    always_comb begin
        if (mode_ff.chain) begin
            selNow = ~pinFilt_ff[`SACS_PIN_CONV]; // [R6]
        end else begin
            selNow = ~(pinFilt_ff[`SACS_PIN_CONV] & pinFilt_ff[`SACS_PIN_SDI]); // [R7] [R4]
        end
    end

    // sequencer state; starts are ignored until the result is stored
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            seq_ff <= SEQ_ACQ;
        end else begin
            case (seq_ff)
                SEQ_ACQ: begin
                    if (startRise) begin
                        seq_ff <= SEQ_CONV; // [R9]
                    end
                end
                SEQ_CONV: begin
                    // length set by the internal timebase only [R1]
                    if (convCnt_ff == CONV_LAST) begin
                        seq_ff <= SEQ_STORE;
                    end
                end
                SEQ_STORE: begin
                    // a full fifo holds the sequencer here and refuses new starts
                    if (fifoInReady) begin
                        seq_ff <= SEQ_ACQ; // [R3]
                    end
                end
                default: begin
                    seq_ff <= SEQ_ACQ;
                end
            endcase
        end
    end

    // conversion timebase, cleared outside conversion
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            convCnt_ff <= '0;
            stepCnt_ff <= '0;
        end else if (seq_ff != SEQ_CONV) begin
            convCnt_ff <= '0;
            stepCnt_ff <= '0;
        end else begin
            convCnt_ff <= convCnt_ff + 1'b1; // [R1]
            if (stepCnt_ff == STEP_LAST) begin
                stepCnt_ff <= '0;
            end else begin
                stepCnt_ff <= stepCnt_ff + 1'b1;
            end
        end
    end

    // successive approximation, msb first, starting at midscale
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sarCode_ff <= `SACS_CODE_ZERO;
            trialBit_ff <= `SACS_CODE_ZERO;
        end else if (seq_ff == SEQ_ACQ && startRise) begin
            sarCode_ff <= `SACS_CODE_MID; // [R11]
            trialBit_ff <= `SACS_CODE_MID;
        end else if (seq_ff == SEQ_CONV && stepCnt_ff == STEP_LAST && trialBit_ff != '0) begin
            // keep the trial bit when the input is at or above the trial level
            if (comparatorHigh) begin
                sarCode_ff <= sarCode_ff | (trialBit_ff >> 1); // [R11]
            end else begin
                sarCode_ff <= (sarCode_ff & ~trialBit_ff) | (trialBit_ff >> 1);
            end
            trialBit_ff <= trialBit_ff >> 1;
        end
    end

    // interface option: chain latched at the start edge, busy at the end
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_ff <= '0;
        end else if (seq_ff == SEQ_ACQ && startRise) begin
            mode_ff.chain <= ~pinFilt_ff[`SACS_PIN_SDI]; // [R8]
        end else if (pushDone) begin
            mode_ff.busy <= selNow; // [R4] [R5]
        end
    end

    // result store pulse
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            convDone_ff <= 1'b0;
        end else begin
            convDone_ff <= pushDone;
        end
    end

    assign pushDone = (seq_ff == SEQ_STORE) && fifoInReady;

    // results wait here; readout takes the oldest unread one
    sacs_fifo #(
        .WIDTH(`SACS_FIFO_WIDTH),
        .DEPTH(`SACS_FIFO_DEPTH)
    ) uFifo (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .inValid(seq_ff == SEQ_STORE),
        .inReady(fifoInReady),
        .inData(sarCode_ff),
        .outValid(fifoOutValid),
        .outReady(popNow),
        .outData(fifoOutData)
    );

    // head is taken only in the shifter branch that loads it, same priority
    assign popNow = !startRise && !pushDone && seq_ff == SEQ_ACQ && selNow
        && loadPend_ff && fifoOutValid;

    // selection history for the select edge
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            selPrev_ff <= 1'b0;
        end else begin
            selPrev_ff <= selNow;
        end
    end

    // serial shifter; clock edges during conversion are ignored [R12]
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            shReg_ff <= '0;
            bitsLeft_ff <= '0;
            sdoOe_ff <= 1'b0;
            loadPend_ff <= 1'b0;
            pendBusy_ff <= 1'b0;
        end else if (startRise) begin
            // new conversion floats the output and drops any open frame
            sdoOe_ff <= 1'b0; // [R9]
            loadPend_ff <= 1'b0;
        end else if (pushDone) begin
            // still selected at the end: busy bit goes out at once
            if (selNow) begin
                shReg_ff <= {`SACS_BUSY_LEVEL, `SACS_CODE_ZERO}; // [R5]
                sdoOe_ff <= 1'b1;
                loadPend_ff <= 1'b1;
                pendBusy_ff <= 1'b1;
            end
        end else if (seq_ff != SEQ_ACQ) begin
            sdoOe_ff <= 1'b0; // [R2]
        end else if (!selNow) begin
            // deselect ends the frame in every option
            sdoOe_ff <= 1'b0; // [R10]
            loadPend_ff <= 1'b0;
        end else if (selNow && !selPrev_ff && !sdoOe_ff) begin
            loadPend_ff <= 1'b1;
            pendBusy_ff <= 1'b0;
        end else if (popNow) begin
            // keep the busy bit in front when the frame carries one
            if (pendBusy_ff) begin
                shReg_ff <= {`SACS_BUSY_LEVEL, fifoOutData}; // [R5]
                bitsLeft_ff <= `SACS_FRAME_BUSY;
            end else begin
                shReg_ff <= {fifoOutData, 1'b0}; // [R10] [R3]
                bitsLeft_ff <= `SACS_FRAME_PLAIN;
            end
            sdoOe_ff <= 1'b1;
            loadPend_ff <= 1'b0;
        end else if (sclkFall && sdoOe_ff && !loadPend_ff) begin
            // chain mode passes the upstream data in behind our bits; a plain frame
            // shifts only the upper 16 bits, so its pad bit never reaches the pin
            if (pendBusy_ff) begin
                shReg_ff <= {shReg_ff[`SACS_RES_BITS-1:0], pinFilt_ff[`SACS_PIN_SDI]}; // [R6]
            end else begin
                shReg_ff <= {shReg_ff[`SACS_RES_BITS-1:1], pinFilt_ff[`SACS_PIN_SDI],
                    1'b0}; // [R6]
            end
            if (!mode_ff.chain) begin
                bitsLeft_ff <= bitsLeft_ff - 1'b1;
                if (bitsLeft_ff == 5'h01) begin
                    sdoOe_ff <= 1'b0; // [R10]
                end
            end
        end
    end

    // pin side of the shifter
    assign serial_data_out = shReg_ff[`SACS_RES_BITS];
    assign serial_data_out_oe = sdoOe_ff;

    // analog control: sample at start, hold isolated through the conversion,
    // then reconnect and sleep; the oscillator runs only while converting
    assign inputIsolate = seq_ff == SEQ_CONV; // [R2]
    assign sampleConnect = seq_ff != SEQ_CONV; // [R3]
    assign powerDown = seq_ff != SEQ_CONV; // [R3]
    assign oscEnable = seq_ff == SEQ_CONV; // [R1]
    assign dacTrial = sarCode_ff;

    // status
    assign convDone = convDone_ff;
    assign modeChain = mode_ff.chain;
    assign modeBusy = mode_ff.busy;

endmodule
